// >>> logic/adccal_pkg.sv
// Package with constants and types for the converter tuning sequencer.
package adccal_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_SPAN = 8'h10;
    localparam logic [7:0] ADDR_CONFIG1 = 8'h14;

    // Field positions.
    localparam int CTRL_EXT_BIT = 0;
    localparam int CFG1_SKIP_TRIM_BIT = 13;
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_IGNORED_BIT = 2;
    localparam int IRQ_W = 3;

    // Full-scale range codes in millivolts peak-to-peak.
    localparam logic [9:0] SPAN_LOW_MV = 10'h258;
    localparam logic [9:0] SPAN_HIGH_MV = 10'h320;
    localparam logic [9:0] SPAN_MIN_MV = 10'h230;
    localparam logic [9:0] SPAN_MAX_MV = 10'h348;
    localparam logic [9:0] SPAN_RESET_MV = 10'h320;

    // Request detector figures in sample-clock cycles.
    localparam int REQ_CYCLES = 80;
    localparam logic [7:0] REQ_LAST = 8'(REQ_CYCLES - 1);

    // Delay and calibration lengths, in nanoseconds, with cycle counts derived at 100 MHz.
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint DLY_SHORT_NS = 10_000;
    localparam longint DLY_LONG_NS = 1_000_000;
    localparam longint TUNE_ADC_NS = 5_000;
    localparam longint TUNE_TRIM_NS = 2_000;
    localparam int DLY_SHORT_CYC = int'((DLY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int DLY_LONG_CYC = int'((DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int TUNE_ADC_CYC = int'((TUNE_ADC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int TUNE_TRIM_CYC = int'((TUNE_TRIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int CNT_W = 24;

    // Sequencer states.
    typedef enum logic [2:0] {
        ADCCAL_WAIT_CLK,
        ADCCAL_PWR_DELAY,
        ADCCAL_IDLE,
        ADCCAL_ARM,
        ADCCAL_TRIM,
        ADCCAL_CONVERT,
        ADCCAL_SLEEP
    } adccal_state_t;

    // Latched AHB address phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } adccal_aphase_t;

    // Request detector phases.
    typedef enum logic [1:0] {
        ADCCAL_REQ_LOW,
        ADCCAL_REQ_HIGH,
        ADCCAL_REQ_ARMED
    } adccal_req_state_t;

endpackage

// >>> logic/adccal_req_detect.sv
// Tuning request detector: low then high for the counted cycles.
`timescale 1ns/1ns
`default_nettype none
module adccal_req_detect
    import adccal_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Request pin and qualifier.
    input wire logic tune_request,
    input wire logic enable,
    // One-cycle pulse when a valid sequence finishes.
    output logic seen
);

    typedef struct packed {
        adccal_req_state_t st;
        logic [7:0] cnt;
        logic seen;
    } adccal_req_reg_t;

    adccal_req_reg_t r_ff;
    adccal_req_reg_t nxt_r;

    // Count the low phase, then the high phase; any early edge restarts.
    always_comb begin
        nxt_r = r_ff;
        nxt_r.seen = 1'b0;
        if (!enable) begin
            nxt_r.st = ADCCAL_REQ_LOW;
            nxt_r.cnt = 8'h00;
        end else begin
            case (r_ff.st)
                ADCCAL_REQ_LOW: begin
                    if (tune_request) begin
                        nxt_r.cnt = 8'h00;
                    end else if (r_ff.cnt == REQ_LAST) begin
                        nxt_r.st = ADCCAL_REQ_ARMED;
                        nxt_r.cnt = 8'h00;
                    end else begin
                        nxt_r.cnt = r_ff.cnt + 8'h01;
                    end
                end
                ADCCAL_REQ_ARMED: begin
                    // Low has lasted long enough; wait for the rise.
                    if (tune_request) begin
                        nxt_r.st = ADCCAL_REQ_HIGH;
                        nxt_r.cnt = 8'h01;
                    end
                end
                ADCCAL_REQ_HIGH: begin
                    if (!tune_request) begin
                        nxt_r.st = ADCCAL_REQ_LOW;
                        nxt_r.cnt = 8'h01;
                    end else if (r_ff.cnt == REQ_LAST) begin
                        // Start falls 80 cycles after the rising transition.
                        nxt_r.seen = 1'b1;
                        nxt_r.st = ADCCAL_REQ_LOW;
                        nxt_r.cnt = 8'h00;
                    end else begin
                        nxt_r.cnt = r_ff.cnt + 8'h01;
                    end
                end
                default: begin
                    nxt_r.st = ADCCAL_REQ_LOW;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_ff <= '{st: ADCCAL_REQ_LOW, cnt: 8'h00, seen: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign seen = r_ff.seen;

endmodule
`default_nettype wire

// >>> logic/adccal_span.sv
// Full-scale span selection between pin and programmed value.
`timescale 1ns/1ns
`default_nettype none
module adccal_span
    import adccal_pkg::*;
(
    // Mode and sources.
    input wire logic ext_mode,
    input wire logic input_span_select,
    input wire logic [9:0] span_prog,
    // Resulting span in millivolts.
    output logic [9:0] span_mv
);

    // Programmed value is clamped to the legal window.
    function automatic logic [9:0] clamp_span(input logic [9:0] v);
        if (v < SPAN_MIN_MV) begin
            clamp_span = SPAN_MIN_MV;
        end else if (v > SPAN_MAX_MV) begin
            clamp_span = SPAN_MAX_MV;
        end else begin
            clamp_span = v;
        end
    endfunction

    // Pin choice in normal mode, programmed choice in extended mode.
    always_comb begin
        if (ext_mode) begin
            span_mv = clamp_span(span_prog);
        end else begin
            span_mv = input_span_select ? SPAN_HIGH_MV : SPAN_LOW_MV;
        end
    end

endmodule
`default_nettype wire

// >>> logic/adccal_top.sv
// Tuning sequencer of the converter with AHB-Lite registers and interrupt.
//
// Summary of operation
// - Busy indicator high exactly while tuning runs.
// - Output strobe stops during termination trimming.
// - Power-up tuning waits the selected delay.
// - Request pin high at power-up skips tuning.
// - Tuning starts 80 cycles after rising edge.
// - Sleep high at power-up holds delay counter.
// - Extended mode forces the short delay.
// - Power-up and default requests trim both parts.
// - Skip bit omits trim in extended mode only, strobe keeps running.
// - Normal mode span: 600 or 800 mV.
// - Extended mode span from programmed value.
// - No sample clock at power-up: analog stays powered down.
// - Same procedure whatever the clock arrival.
// - Sleep during tuning waits for completion.
// - Requests are ignored while asleep.
`timescale 1ns/1ns
`default_nettype none
module adccal_top
    import adccal_pkg::*;
#(
    parameter int DLY_SHORT = DLY_SHORT_CYC,
    parameter int DLY_LONG = DLY_LONG_CYC,
    parameter int TUNE_ADC = TUNE_ADC_CYC,
    parameter int TUNE_TRIM = TUNE_TRIM_CYC
) (
    // Clock and reset; reset stands for power-up.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Control pins.
    input wire logic tune_request,
    input wire logic tune_delay_select,
    input wire logic sleep_pin,
    input wire logic input_span_select,
    input wire logic sample_clk_present,
    // Status and derived controls.
    output logic tune_in_progress,
    output logic output_strobe,
    output logic analog_powered_down,
    output logic [9:0] span_mv,
    output logic irq
);

    // All module state in one record.
    typedef struct packed {
        adccal_state_t st;
        logic [CNT_W-1:0] cnt;
        logic skip_boot;
        logic trim_this;
        logic busy;
        logic strobe;
        logic asleep;
        logic ana_pd;
        logic [9:0] span;
        logic ext_mode;
        logic skip_trim;
        logic [9:0] span_prog;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        adccal_aphase_t ap;
        logic boot_seen;
    } adccal_reg_t;

    adccal_reg_t r_ff;
    adccal_reg_t nxt_r;
    logic req_seen;
    logic [9:0] span_sel;
    logic [IRQ_W-1:0] ev;

    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Request detector; disabled while asleep so pin activity leaves no partial count behind.
    adccal_req_detect u_req (
        .hclk(hclk),
        .hresetn(hresetn),
        .tune_request(tune_request),
        .enable(!r_ff.asleep && !sleep_pin),
        .seen(req_seen)
    );

    // Span mapping.
    adccal_span u_span (
        .ext_mode(r_ff.ext_mode),
        .input_span_select(input_span_select),
        .span_prog(r_ff.span_prog),
        .span_mv(span_sel)
    );

    // Cycle count of a delay parameter, at the counter width.
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    // Word read back at an offset.
    function automatic logic [31:0] rd_word(input adccal_reg_t s, input logic [7:0] a);
        rd_word = 32'h0000_0000;
        if (a == ADDR_CTRL) begin
            rd_word[CTRL_EXT_BIT] = s.ext_mode;
        end else if (a == ADDR_STATUS) begin
            rd_word = {24'h0, s.asleep, s.ana_pd, s.strobe, s.trim_this, s.busy, s.st};
        end else if (a == ADDR_IRQ_STAT) begin
            rd_word[IRQ_W-1:0] = s.irq_stat;
        end else if (a == ADDR_IRQ_MASK) begin
            rd_word[IRQ_W-1:0] = s.irq_mask;
        end else if (a == ADDR_SPAN) begin
            rd_word = {22'h0, s.span_prog};
        end else if (a == ADDR_CONFIG1) begin
            rd_word[CFG1_SKIP_TRIM_BIT] = s.skip_trim;
        end
    endfunction

    // Next-state logic: sequencer, bus slave and interrupt.
    always_comb begin
        nxt_r = r_ff;
        ev = '0;
        nxt_r.span = span_sel;
        if (r_ff.st != ADCCAL_TRIM) begin
            nxt_r.strobe = ~r_ff.strobe;
        end
        // The strap is taken once, on the first clock after reset release.
        if (!r_ff.boot_seen) begin
            nxt_r.boot_seen = 1'b1;
            nxt_r.skip_boot = tune_request;
        end
        case (r_ff.st)
            ADCCAL_WAIT_CLK: begin
                // Analog held down until the sample clock runs; the same
                // path follows in either case.
                nxt_r.ana_pd = 1'b1;
                if (sample_clk_present && r_ff.boot_seen) begin
                    nxt_r.ana_pd = 1'b0;
                    nxt_r.st = ADCCAL_PWR_DELAY;
                    nxt_r.cnt = '0;
                end
            end
            ADCCAL_PWR_DELAY: begin
                // Sleep held at power-up keeps the analog side down as well.
                nxt_r.ana_pd = sleep_pin && !r_ff.skip_boot;
                if (r_ff.skip_boot) begin
                    nxt_r.st = ADCCAL_IDLE;
                end else if (!sleep_pin) begin
                    // Counter frozen while sleep is held.
                    nxt_r.cnt = r_ff.cnt + CNT_ONE;
                    if (r_ff.cnt + CNT_ONE >= ((r_ff.ext_mode || !tune_delay_select) ?
                            cyc(DLY_SHORT) : cyc(DLY_LONG))) begin
                        nxt_r.st = ADCCAL_TRIM;
                        nxt_r.trim_this = 1'b1;
                        nxt_r.busy = 1'b1;
                        nxt_r.cnt = '0;
                        ev[IRQ_START_BIT] = 1'b1;
                    end
                end
            end
            ADCCAL_IDLE: begin
                if (sleep_pin) begin
                    nxt_r.st = ADCCAL_SLEEP;
                    nxt_r.asleep = 1'b1;
                    nxt_r.ana_pd = 1'b1;
                end else if (req_seen) begin
                    nxt_r.busy = 1'b1;
                    nxt_r.cnt = '0;
                    ev[IRQ_START_BIT] = 1'b1;
                    if (r_ff.ext_mode && r_ff.skip_trim) begin
                        nxt_r.trim_this = 1'b0;
                        nxt_r.st = ADCCAL_CONVERT;
                    end else begin
                        nxt_r.trim_this = 1'b1;
                        nxt_r.st = ADCCAL_TRIM;
                    end
                end
            end
            ADCCAL_TRIM: begin
                nxt_r.cnt = r_ff.cnt + CNT_ONE;
                if (r_ff.cnt + CNT_ONE >= cyc(TUNE_TRIM)) begin
                    nxt_r.st = ADCCAL_CONVERT;
                    nxt_r.cnt = '0;
                end
            end
            ADCCAL_CONVERT: begin
                // Sleep is not looked at until the sequence ends.
                nxt_r.cnt = r_ff.cnt + CNT_ONE;
                if (r_ff.cnt + CNT_ONE >= cyc(TUNE_ADC)) begin
                    nxt_r.st = ADCCAL_IDLE;
                    nxt_r.busy = 1'b0;
                    nxt_r.trim_this = 1'b0;
                    nxt_r.cnt = '0;
                    ev[IRQ_DONE_BIT] = 1'b1;
                end
            end
            ADCCAL_SLEEP: begin
                if (req_seen || tune_request) begin
                    ev[IRQ_IGNORED_BIT] = tune_request && !r_ff.irq_stat[IRQ_IGNORED_BIT];
                end
                if (!sleep_pin) begin
                    nxt_r.st = ADCCAL_IDLE;
                    nxt_r.asleep = 1'b0;
                    nxt_r.ana_pd = 1'b0;
                end
            end
            default: begin
                nxt_r.st = ADCCAL_WAIT_CLK;
            end
        endcase
        // Bus data phase: writes use the latched address.
        if (r_ff.ap.valid && r_ff.ap.write) begin
            if (r_ff.ap.addr == ADDR_CTRL) begin
                nxt_r.ext_mode = hwdata[CTRL_EXT_BIT];
            end else if (r_ff.ap.addr == ADDR_IRQ_STAT) begin
                nxt_r.irq_stat = r_ff.irq_stat & ~hwdata[IRQ_W-1:0];
            end else if (r_ff.ap.addr == ADDR_IRQ_MASK) begin
                nxt_r.irq_mask = hwdata[IRQ_W-1:0];
            end else if (r_ff.ap.addr == ADDR_SPAN) begin
                nxt_r.span_prog = hwdata[9:0];
            end else if (r_ff.ap.addr == ADDR_CONFIG1) begin
                nxt_r.skip_trim = hwdata[CFG1_SKIP_TRIM_BIT];
            end
        end
        // A set in the same cycle as a clear wins.
        nxt_r.irq_stat = nxt_r.irq_stat | ev;
        nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
        // Address phase capture; reads answer with zero wait states.
        nxt_r.ap.valid = hsel && hready && htrans[1];
        nxt_r.ap.write = hwrite;
        nxt_r.ap.addr = haddr[7:0];
        nxt_r.rdata = '0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            nxt_r.rdata = rd_word(r_ff, haddr[7:0]);
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_ff <= '{st: ADCCAL_WAIT_CLK, span: SPAN_RESET_MV, span_prog: SPAN_RESET_MV,
                      ana_pd: 1'b1, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from the state register; ready and response are constant.
    assign tune_in_progress = r_ff.busy;
    assign output_strobe = r_ff.strobe;
    assign analog_powered_down = r_ff.ana_pd;
    assign span_mv = r_ff.span;
    assign irq = r_ff.irq;
    assign hrdata = r_ff.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule
`default_nettype wire

// >>> test/adccal_host.sv
// Host model that drives the converter's control pins.
`timescale 1ns/1ns
`default_nettype none
module adccal_host (
    // Clock.
    input wire logic hclk,
    // Control pins toward the converter.
    output logic tune_request,
    output logic tune_delay_select,
    output logic sleep_pin,
    output logic input_span_select,
    output logic sample_clk_present
);
    // Pins start at a defined level so nothing floats before reset.
    initial begin
        tune_request = 1'b0;
        tune_delay_select = 1'b0;
        sleep_pin = 1'b0;
        input_span_select = 1'b0;
        sample_clk_present = 1'b1;
    end

    // Static straps change just after an edge, so the block never sees them mid-cycle.
    task automatic set_pins(input logic req, input logic dly, input logic slp,
                            input logic span, input logic clkp);
        @(posedge hclk);
        tune_request <= req;
        tune_delay_select <= dly;
        sleep_pin <= slp;
        input_span_select <= span;
        sample_clk_present <= clkp;
    endtask

    // Holds the request pin for exactly n sampling edges; a request is a low then a high call.
    task automatic hold_req(input logic lvl, input int n);
        @(posedge hclk);
        tune_request <= lvl;
        repeat (n - 1) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// >>> test/adccal_top_assertions.sv
// Checker of the tuning sequencer's pin behaviour, bound to the top module.
`timescale 1ns/1ns
`default_nettype none
module adccal_checker
    import adccal_pkg::*;
#(
    parameter int TUNE_ADC = TUNE_ADC_CYC
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Pins watched.
    input wire logic tune_request,
    input wire logic tune_in_progress,
    input wire logic output_strobe,
    input wire logic analog_powered_down,
    input wire logic [9:0] span_mv,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] hi_cnt_ff;
    logic [15:0] run_cnt_ff;

    // Counts request-high samples and tuning cycles; the first saturates so it cannot wrap.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cnt_ff <= 8'h00;
            run_cnt_ff <= 16'h0000;
        end else begin
            hi_cnt_ff <= !tune_request ? 8'h00 : (&hi_cnt_ff ? hi_cnt_ff : hi_cnt_ff + 8'h01);
            run_cnt_ff <= tune_in_progress ? run_cnt_ff + 16'h0001 : 16'h0000;
        end
    end

    strobe_run_a: assert property (
        $past(hresetn) && !tune_in_progress && !$past(tune_in_progress)
        |-> output_strobe != $past(output_strobe)) else $error("strobe stalled outside tuning");
    tune_hold_a: assert property (
        $rose(tune_in_progress) |-> tune_in_progress[*8]) else $error("tuning flag too short");
    tune_len_a: assert property (
        $fell(tune_in_progress) |-> run_cnt_ff >= 16'(TUNE_ADC)) else $error("tuning cut short");
    tune_end_a: assert property (
        $rose(tune_in_progress) |-> ##[1:1000] !tune_in_progress) else $error("tuning never ends");
    tune_power_a: assert property (
        tune_in_progress |-> !analog_powered_down) else $error("powered down while tuning");
    sleep_ignore_a: assert property (
        $rose(tune_in_progress) |-> !$past(analog_powered_down)) else $error("tuned from sleep");
    req_len_a: assert property (
        $rose(tune_in_progress) && tune_request |-> hi_cnt_ff >= 8'h50)
        else $error("tuning before request high time");
    span_range_a: assert property (
        span_mv >= SPAN_MIN_MV && span_mv <= SPAN_MAX_MV) else $error("span out of range");

    // Main scenarios: a requested tuning, an interrupt, a sleep after tuning.
    cover property ($rose(tune_in_progress) && tune_request);
    cover property ($rose(irq));
    cover property ($fell(tune_in_progress) ##[1:4] analog_powered_down);
endmodule

bind adccal_top adccal_checker #(.TUNE_ADC(TUNE_ADC)) chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .tune_request(tune_request),
    .tune_in_progress(tune_in_progress),
    .output_strobe(output_strobe),
    .analog_powered_down(analog_powered_down),
    .span_mv(span_mv),
    .irq(irq)
);
`default_nettype wire

// >>> test/adccal_top_tb.sv
// Self-checking bench of the tuning sequencer, its pins, registers and interrupt.
`timescale 1ns/1ns
`default_nettype none
module adccal_top_tb
    import adccal_pkg::*;
;
    localparam int DS = 20, DL = 40, TA = 10, TT = 5;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic tune_request, tune_delay_select, sleep_pin, input_span_select, sample_clk_present;
    logic tune_in_progress, output_strobe, analog_powered_down;
    logic [9:0] span_mv;
    int error_cnt, n_checks, n, len, frz;

    // The single slave's ready closes the bus loop.
    assign hready = hreadyout;

    adccal_top #(.DLY_SHORT(DS), .DLY_LONG(DL), .TUNE_ADC(TA), .TUNE_TRIM(TT)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tune_request(tune_request),
        .tune_delay_select(tune_delay_select), .sleep_pin(sleep_pin),
        .input_span_select(input_span_select), .sample_clk_present(sample_clk_present),
        .tune_in_progress(tune_in_progress), .output_strobe(output_strobe),
        .analog_powered_down(analog_powered_down), .span_mv(span_mv), .irq(irq));

    adccal_host host (
        .hclk(hclk), .tune_request(tune_request), .tune_delay_select(tune_delay_select),
        .sleep_pin(sleep_pin), .input_span_select(input_span_select),
        .sample_clk_present(sample_clk_present));

    // Free-running 100 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Timing figures are checked against a window, since pipeline depth is the design's choice.
    task automatic in_win(input string what, input int v, input int lo, input int hi);
        check(what, 32'(v >= lo && v <= hi), 32'h1);
    endtask

    // Waits as long as the slave needs; only the watchdog ends a hang.
    task automatic wait_rdy();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask

    // One single AHB-Lite word transfer; read data is taken at the edge ending the data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        bus(1'b0, a, 32'h0);
        check(what, r, e);
        check("hresp", 32'(hresp), 32'h0);
    endtask

    task automatic span_set(input logic [31:0] d, input logic [9:0] e);
        wr(ADDR_SPAN, d);
        repeat (3) @(posedge hclk);
        check("span prog", 32'(span_mv), 32'(e));
    endtask

    // Power-up: straps are set, then reset is held for two edges.
    task automatic pwr(input logic req, input logic dly, input logic slp, input logic clkp);
        host.set_pins(req, dly, slp, 1'b0, clkp);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic wait_tip(output int c);
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (tune_in_progress !== 1'b1 && c < 400);
    endtask

    // Measures the tuning length and how many of its cycles the strobe stood still.
    task automatic run(output int l, output int f);
        logic p;
        l = 0;
        f = 0;
        p = ~output_strobe;
        while (tune_in_progress === 1'b1 && l < 400) begin
            l++;
            if (output_strobe === p) f++;
            p = output_strobe;
            @(posedge hclk);
        end
    endtask

    // Watchdog sized well above the roughly 1500 cycles the sequence needs.
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        pwr(1'b0, 1'b0, 1'b0, 1'b1);
        wait_tip(n);
        in_win("short delay", n, DS, DS + 5);
        run(len, frz);
        in_win("tune length", len, TT + TA, TT + TA + 2);
        in_win("trim stop", frz, TT - 1, TT + 1);
        rd(ADDR_CTRL, 32'h0, "ctrl reset");
        rd(ADDR_SPAN, 32'(SPAN_RESET_MV), "span reset");
        rd(8'h20, 32'h0, "unmapped");
        rd(ADDR_IRQ_STAT, 32'h3, "irq start done");
        wr(ADDR_IRQ_MASK, 32'h0);
        check("irq masked", 32'(irq), 32'h0);
        wr(ADDR_IRQ_MASK, 32'h2);
        rd(ADDR_IRQ_MASK, 32'h2, "mask");
        check("irq up", 32'(irq), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h3);
        rd(ADDR_IRQ_STAT, 32'h0, "irq cleared");
        check("irq down", 32'(irq), 32'h0);
        check("span low", 32'(span_mv), 32'(SPAN_LOW_MV));
        host.set_pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        repeat (3) @(posedge hclk);
        check("span high", 32'(span_mv), 32'(SPAN_HIGH_MV));
        pwr(1'b0, 1'b1, 1'b0, 1'b1);
        wait_tip(n);
        in_win("long delay", n, DL, DL + 5);
        run(len, frz);
        pwr(1'b0, 1'b1, 1'b0, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        wait_tip(n);
        in_win("ext delay", n, DS - 5, DS + 5);
        run(len, frz);
        pwr(1'b0, 1'b0, 1'b1, 1'b1);
        repeat (60) @(posedge hclk);
        check("asleep at power-up", 32'({tune_in_progress, analog_powered_down}), 32'h1);
        host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        wait_tip(n);
        in_win("wake delay", n, DS, DS + 6);
        run(len, frz);
        pwr(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (40) @(posedge hclk);
        check("no clock", 32'({tune_in_progress, analog_powered_down}), 32'h1);
        host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        wait_tip(n);
        in_win("late clock delay", n, DS, DS + 6);
        run(len, frz);
        in_win("late clock length", len, TT + TA, TT + TA + 2);
        pwr(1'b1, 1'b0, 1'b0, 1'b1);
        repeat (60) @(posedge hclk);
        check("strap skip", 32'(tune_in_progress), 32'h0);
        host.hold_req(1'b0, 79);
        host.hold_req(1'b1, 30);
        host.hold_req(1'b0, 80);
        host.hold_req(1'b1, 79);
        host.hold_req(1'b0, 80);
        host.hold_req(1'b1, 1);
        wait_tip(n);
        in_win("request start", n, 80, 84);
        run(len, frz);
        in_win("request trim", frz, TT - 1, TT + 1);
        host.hold_req(1'b0, 80);
        host.hold_req(1'b1, 1);
        wait_tip(n);
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        run(len, frz);
        in_win("sleep waits", len, TT + TA - 1, TT + TA + 1);
        repeat (3) @(posedge hclk);
        check("asleep after", 32'(analog_powered_down), 32'h1);
        host.hold_req(1'b0, 80);
        host.hold_req(1'b1, 100);
        check("ignored", 32'(tune_in_progress), 32'h0);
        rd(ADDR_IRQ_STAT, 32'h7, "ignored flag");
        wr(ADDR_IRQ_STAT, 32'h7);
        host.set_pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_CONFIG1, 32'h2000);
        span_set(32'h2BC, 10'h2BC);
        span_set(32'h384, SPAN_MAX_MV);
        span_set(32'h1F4, SPAN_MIN_MV);
        host.hold_req(1'b0, 80);
        host.hold_req(1'b1, 1);
        wait_tip(n);
        run(len, frz);
        in_win("skip length", len, TA, TA + 2);
        check("skip strobe", 32'(frz), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
